// *** verilog/standby_defs.svh ***
// Timing counts and pin layout for the standby and reset controller.
// Assumes a 100 MHz system clock; all timing counts but ERASE_CYC derive from it here.
// Operation
// R01: Each registered output can be forced high or low on a device clock edge for test.
// R02: Without a power-down pin, the block sleeps once no input has moved for the idle period.
// R03: The idle period from the last active input to standby lies between 100 ns and 250 ns.
// R04: Without a power-down pin, any detected input or I/O transition wakes the block.
// R05: A pulse wider than 5 ns counts as a transition; the code counts only a pulse that spans a sample edge of the 10 ns clock.
// R06: A pulse narrower than 1 ns never counts as a wake-up transition; the code counts one that spans a sample edge.
// R07: Leaving standby adds at most 15 ns before outputs are valid again.
// R08: The power-down pin is active high and a high level puts the block in standby.
// R09: The power-down pin is never passed to the logic array as an input.
// R10: After the power-down pin falls, outputs are valid within 35 ns.
// R11: Power-up reset clears every internal register to low within 10 microseconds.
// R12: After reset, each enabled output pin shows the cleared register through its polarity.
// R13: The far side keeps the device clock static during power-up.
// R14: The far side gives no clock edge after power-up until setup times are met.
// R15: Programming erases the array first by itself, with no separate erase step.
// R16: Register contents are kept in standby and operation resumes from them on wake-up.
`ifndef STANDBY_DEFS_SVH
`define STANDBY_DEFS_SVH

`define CLK_PERIOD_NS      10
`define IDLE_MIN_NS        100
`define IDLE_MAX_NS        250
`define IDLE_CYC           ((`IDLE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IDLE_MAX_CYC       (`IDLE_MAX_NS / `CLK_PERIOD_NS)
`define DETECT_NS          5
`define IGNORE_NS          1
`define DETECT_CYC         ((`DETECT_NS / `CLK_PERIOD_NS) < 1 ? 1 : (`DETECT_NS / `CLK_PERIOD_NS))
`define WAKE_NS            15
`define WAKE_CYC           ((`WAKE_NS / `CLK_PERIOD_NS) < 1 ? 1 : (`WAKE_NS / `CLK_PERIOD_NS))
`define PIN_REL_NS         35
`define PIN_REL_CYC        ((`PIN_REL_NS / `CLK_PERIOD_NS) < 1 ? 1 : (`PIN_REL_NS / `CLK_PERIOD_NS))
`define POR_NS             10000
`define POR_CYC            (`POR_NS / `CLK_PERIOD_NS)
`define ERASE_CYC          4
`define N_PINS             22
`define N_MACRO            10
`define PD_PIN_IDX         4

`endif

// *** verilog/standby_pkg.sv ***
// Types shared by the standby and reset controller.
// Assumes standby_defs.svh supplies the numbers.
package standby_pkg;

  // Gray along reset, active, standby, wake.
  typedef enum logic [2:0] {
    ST_POR     = 3'h0,
    ST_ACTIVE  = 3'h1,
    ST_STANDBY = 3'h3,
    ST_WAKE    = 3'h2,
    ST_ERASE   = 3'h6,
    ST_PROGRAM = 3'h7
  } mode_e;

  typedef struct packed {
    logic standby;
    logic out_valid;
    logic reset_done;
    logic prog_busy;
  } status_s;

endpackage : standby_pkg

// *** verilog/pin_activity_filter.sv ***
// Per-pin transition detector with a pulse-width filter.
// Assumes inputs already synchronous to the system clock.
`timescale 1ns/100ps
`default_nettype none
module pin_activity_filter #(
  parameter int N_IN   = 23,
  parameter int FILT_C = 1
) (
  // Clock and control
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            ce_i,
  // Pins
  input  wire logic [N_IN-1:0] pin_i,
  input  wire logic [N_IN-1:0] mask_i,
  // Result
  output logic                 active_o
);

  localparam int CW = $clog2(FILT_C + 1);

  typedef struct packed {
    logic [N_IN-1:0]         level;
    logic [N_IN-1:0][CW-1:0] cnt;
    logic                    hit;
  } filt_s;

  filt_s cur_reg;
  filt_s cur_next;
  logic [N_IN-1:0]         lvl_n;
  logic [N_IN-1:0][CW-1:0] cnt_n;
  logic [N_IN-1:0]         hit_n;

  if (FILT_C < 1)
    $error("FILT_C must be at least 1");

  // A pin counts only after its new level has been seen for FILT_C samples.
  // Pulses shorter than one sample period are seen only if a sample edge falls inside them.
  genvar g;
  for (g = 0; g < N_IN; g++)
  begin : g_pin
    // R05 R06 width filter
    always_comb
    begin
      lvl_n[g] = cur_reg.level[g];
      cnt_n[g] = '0;
      hit_n[g] = 1'b0;
      if (pin_i[g] != cur_reg.level[g])
      begin
        if (32'(cur_reg.cnt[g]) + 1 >= FILT_C)
        begin
          lvl_n[g] = pin_i[g];
          hit_n[g] = mask_i[g];
        end
        else
        begin
          cnt_n[g] = cur_reg.cnt[g] + CW'(1);
        end
      end
    end
  end

  always_comb
  begin
    cur_next.level = lvl_n;
    cur_next.cnt   = cnt_n;
    cur_next.hit   = |hit_n;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cur_reg <= '0;
    else if (ce_i)
      cur_reg <= cur_next;
  end

  assign active_o = cur_reg.hit;

endmodule : pin_activity_filter
`default_nettype wire

// *** verilog/standby_reset_ctrl.sv ***
// Standby, wake, power-up reset, preload and programming control of a
// small programmable logic device with ten registered macrocells.
// Assumes all pins are sampled synchronously at CLK_SYS_I; the device clock
// pin DEV_CLK_I is an ordinary input whose rising edges clock the macrocells.
`timescale 1ns/100ps
`default_nettype none
`include "standby_defs.svh"
module standby_reset_ctrl #(
  parameter int N_PINS     = `N_PINS,
  parameter int N_MACRO    = `N_MACRO,
  parameter bit PD_VARIANT = 1'b0,
  parameter int PD_IDX     = `PD_PIN_IDX,
  parameter int IDLE_C     = `IDLE_CYC,
  parameter int WAKE_C     = `WAKE_CYC,
  parameter int PIN_REL_C  = `PIN_REL_CYC,
  parameter int POR_C      = `POR_CYC,
  parameter int ERASE_C    = `ERASE_CYC
) (
  // Clock, reset, enable
  input  wire logic               CLK_SYS_I,
  input  wire logic               RST_N_I,
  input  wire logic               CE_I,
  // Device pins
  input  wire logic [N_PINS-1:0]  PIN_I,
  input  wire logic               DEV_CLK_I,
  input  wire logic               POWER_DOWN_PIN_I,
  // Macrocell next state and preload
  input  wire logic [N_MACRO-1:0] D_I,
  input  wire logic               PRELOAD_EN_I,
  input  wire logic [N_MACRO-1:0] PRELOAD_DATA_I,
  // Programming
  input  wire logic               PROG_START_I,
  input  wire logic [N_MACRO-1:0] PROG_INV_I,
  input  wire logic [N_MACRO-1:0] PROG_OE_I,
  // Outputs
  output logic [N_MACRO-1:0]      Q_O,
  output logic [N_MACRO-1:0]      Q_OE_O,
  output logic [N_MACRO-1:0]      FB_O,
  output logic [N_PINS-1:0]       ARRAY_IN_O,
  output logic                    STANDBY_O,
  output logic                    OUT_VALID_O,
  output logic                    RESET_DONE_O,
  output logic                    PROG_BUSY_O
);

  // The one shared counter must reach the longest of all the counts.
  localparam int M_IDLE = (POR_C > IDLE_C) ? POR_C : IDLE_C;
  localparam int M_ERAS = (M_IDLE > ERASE_C) ? M_IDLE : ERASE_C;
  localparam int M_REL  = (M_ERAS > PIN_REL_C) ? M_ERAS : PIN_REL_C;
  localparam int M_ALL  = (M_REL > WAKE_C) ? M_REL : WAKE_C;
  localparam int CW     = $clog2(M_ALL + 1);

  typedef struct packed {
    standby_pkg::mode_e     mode;
    logic [CW-1:0]          cnt;
    logic                   clk_prev;
    logic [N_MACRO-1:0]     q;
    logic [N_MACRO-1:0]     inv;
    logic [N_MACRO-1:0]     oe;
    logic [N_MACRO-1:0]     pin;
    logic [N_MACRO-1:0]     pin_oe;
    logic [N_PINS-1:0]      arr_in;
    standby_pkg::status_s   stat;
  } ctrl_s;

  // Unprogrammed cells power up as plain, disabled outputs.
  ctrl_s st_reg = '0;
  ctrl_s st_next;
  logic  activity;
  logic  clk_rise;
  logic  pd_high;
  logic [N_PINS:0] act_mask;

  if (IDLE_C < `IDLE_CYC || IDLE_C > `IDLE_MAX_CYC)
    $error("IDLE_C outside idle window");
  if (PD_IDX < 0 || PD_IDX >= N_PINS)
    $error("PD_IDX outside pin range");
  if (POR_C < 1 || WAKE_C < 1 || PIN_REL_C < 1 || ERASE_C < 1)
    $error("counts must be positive");

  // ==========================================================================
  // Transition detection
  // ==========================================================================
  // R09 pin kept out
  always_comb
  begin
    act_mask = '1;
    if (PD_VARIANT)
      act_mask[PD_IDX] = 1'b0;
  end

  pin_activity_filter #(
    .N_IN   (N_PINS + 1),
    .FILT_C (`DETECT_CYC)
  ) u_filter (
    .clk_i    (CLK_SYS_I),
    .rst_n_i  (RST_N_I),
    .ce_i     (CE_I),
    .pin_i    ({DEV_CLK_I, PIN_I}),
    .mask_i   (act_mask),
    .active_o (activity)
  );

  assign clk_rise = DEV_CLK_I & ~st_reg.clk_prev;
  // R08 active high
  assign pd_high  = PD_VARIANT & POWER_DOWN_PIN_I;

  // ==========================================================================
  // Control state
  // ==========================================================================
  always_comb
  begin
    st_next          = st_reg;
    st_next.clk_prev = DEV_CLK_I;
    st_next.arr_in   = PIN_I;
    // R09 pin kept out
    if (PD_VARIANT)
      st_next.arr_in[PD_IDX] = 1'b0;

    case (st_reg.mode)
      standby_pkg::ST_POR:
      begin
        // R11 registers held low
        st_next.q = '0;
        st_next.cnt = st_reg.cnt + CW'(1);
        if (32'(st_reg.cnt) + 1 >= POR_C)
        begin
          st_next.mode            = standby_pkg::ST_ACTIVE;
          st_next.cnt             = '0;
          st_next.stat.reset_done = 1'b1;
          st_next.stat.out_valid  = 1'b1;
        end
      end

      standby_pkg::ST_ACTIVE:
      begin
        if (clk_rise)
        begin
          // R01 synchronous preload
          if (PRELOAD_EN_I)
            st_next.q = PRELOAD_DATA_I;
          else
            st_next.q = D_I;
        end
        if (PROG_START_I)
        begin
          // R15 erase before write
          st_next.mode           = standby_pkg::ST_ERASE;
          st_next.cnt            = '0;
          st_next.stat.prog_busy = 1'b1;
          st_next.inv            = '0;
          st_next.oe             = '0;
        end
        else if (pd_high)
        begin
          st_next.mode           = standby_pkg::ST_STANDBY;
          st_next.stat.standby   = 1'b1;
          st_next.stat.out_valid = 1'b0;
        end
        else if (!PD_VARIANT)
        begin
          // R02 R03 idle count
          if (activity)
            st_next.cnt = '0;
          else if (32'(st_reg.cnt) + 1 >= IDLE_C)
          begin
            st_next.mode           = standby_pkg::ST_STANDBY;
            st_next.cnt            = '0;
            st_next.stat.standby   = 1'b1;
            st_next.stat.out_valid = 1'b0;
          end
          else
            st_next.cnt = st_reg.cnt + CW'(1);
        end
      end

      standby_pkg::ST_STANDBY:
      begin
        // R16 state retained
        st_next.q = st_reg.q;
        st_next.cnt = '0;
        if (PD_VARIANT ? !POWER_DOWN_PIN_I : activity)
        begin
          // R04 wake on transition
          st_next.mode         = standby_pkg::ST_WAKE;
          st_next.stat.standby = 1'b0;
        end
      end

      standby_pkg::ST_WAKE:
      begin
        // Clock edges are still honoured here; Q_O follows at once and only OUT_VALID_O lags.
        if (clk_rise)
          st_next.q = PRELOAD_EN_I ? PRELOAD_DATA_I : D_I;
        st_next.cnt = st_reg.cnt + CW'(1);
        if (pd_high)
        begin
          st_next.mode         = standby_pkg::ST_STANDBY;
          st_next.stat.standby = 1'b1;
          st_next.cnt          = '0;
        end
        // R07 R10 wake delay
        else if (32'(st_reg.cnt) + 1 >= (PD_VARIANT ? PIN_REL_C : WAKE_C))
        begin
          st_next.mode           = standby_pkg::ST_ACTIVE;
          st_next.cnt            = '0;
          st_next.stat.out_valid = 1'b1;
        end
      end

      standby_pkg::ST_ERASE:
      begin
        // R15 automatic erase
        st_next.inv = '0;
        st_next.oe  = '0;
        st_next.cnt = st_reg.cnt + CW'(1);
        if (32'(st_reg.cnt) + 1 >= ERASE_C)
        begin
          st_next.mode = standby_pkg::ST_PROGRAM;
          st_next.cnt  = '0;
        end
      end

      standby_pkg::ST_PROGRAM:
      begin
        st_next.inv            = PROG_INV_I;
        st_next.oe             = PROG_OE_I;
        st_next.q              = '0;
        st_next.mode           = standby_pkg::ST_ACTIVE;
        st_next.stat.prog_busy = 1'b0;
      end

      default:
      begin
        st_next.mode = standby_pkg::ST_POR;
        st_next.cnt  = '0;
      end
    endcase

    // R12 polarity on output
    st_next.pin    = st_next.q ^ st_next.inv;
    st_next.pin_oe = st_next.oe;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // The programmed configuration survives reset, as it would in the cells.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      // R11 power-up clear
      st_reg.mode     <= standby_pkg::ST_POR;
      st_reg.cnt      <= '0;
      st_reg.clk_prev <= 1'b0;
      st_reg.q        <= '0;
      st_reg.pin      <= '0;
      st_reg.pin_oe   <= '0;
      st_reg.arr_in   <= '0;
      st_reg.stat     <= '0;
      st_reg.inv      <= st_reg.inv;
      st_reg.oe       <= st_reg.oe;
    end
    else if (CE_I)
      st_reg <= st_next;
  end

  assign Q_O          = st_reg.pin;
  assign Q_OE_O       = st_reg.pin_oe;
  assign FB_O         = st_reg.q;
  assign ARRAY_IN_O   = st_reg.arr_in;
  assign STANDBY_O    = st_reg.stat.standby;
  assign OUT_VALID_O  = st_reg.stat.out_valid;
  assign RESET_DONE_O = st_reg.stat.reset_done;
  assign PROG_BUSY_O  = st_reg.stat.prog_busy;

endmodule : standby_reset_ctrl
`default_nettype wire

// *** sim/sby_chk_asserts.sv ***
// Port checker for the standby and reset controller, bound to the design.
// Assumes the clock enable held high; idle and wake checks cover the
// transition-detect variant only.
`timescale 1ns/100ps
`default_nettype none
module sby_chk #(
  parameter int N_PINS  = 22,
  parameter int N_MACRO = 10,
  parameter bit PD_VARIANT = 1'b0
) (
  // Stimulus
  input wire logic               CLK_SYS_I,
  input wire logic               RST_N_I,
  input wire logic               CE_I,
  input wire logic [N_PINS-1:0]  PIN_I,
  input wire logic               DEV_CLK_I,
  input wire logic               PRELOAD_EN_I,
  input wire logic [N_MACRO-1:0] PRELOAD_DATA_I,
  // Results
  input wire logic [N_MACRO-1:0] Q_O,
  input wire logic [N_MACRO-1:0] Q_OE_O,
  input wire logic [N_MACRO-1:0] FB_O,
  input wire logic               STANDBY_O,
  input wire logic               OUT_VALID_O,
  input wire logic               RESET_DONE_O,
  input wire logic               PROG_BUSY_O
);
  // Edges since the last pin or clock change; reset or programming restarts it.
  logic [5:0]        quiet_reg;
  logic [N_PINS-1:0] pin_reg;
  logic              dclk_reg;
  logic              run;
  assign run = RESET_DONE_O && !STANDBY_O && !PROG_BUSY_O && CE_I;
  always_ff @(posedge CLK_SYS_I)
  begin
    pin_reg  <= PIN_I;
    dclk_reg <= DEV_CLK_I;
    if (!RESET_DONE_O || PROG_BUSY_O || PIN_I != pin_reg || DEV_CLK_I != dclk_reg)
      quiet_reg <= 6'h00;
    else if (CE_I && quiet_reg != 6'h3F)
      quiet_reg <= quiet_reg + 6'h01;
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  property p_rst;
    disable iff (1'b0) !RST_N_I |=> FB_O == '0 && !RESET_DONE_O && !STANDBY_O;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left state set");
  property p_pre;
    run && $rose(DEV_CLK_I) && PRELOAD_EN_I |=> FB_O == $past(PRELOAD_DATA_I);
  endproperty
  a_pre: assert property (p_pre) else $error("preload not taken");
  property p_hold;
    STANDBY_O |=> $stable(FB_O) && $stable(Q_O);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved in standby");
  property p_idle_min;
    !PD_VARIANT && $rose(STANDBY_O) |-> quiet_reg >= 6'h0A;
  endproperty
  a_idle_min: assert property (p_idle_min) else $error("standby too early");
  property p_idle_max;
    !PD_VARIANT && RESET_DONE_O && !PROG_BUSY_O && !STANDBY_O |-> quiet_reg <= 6'h19;
  endproperty
  a_idle_max: assert property (p_idle_max) else $error("standby too late");
  property p_wake;
    !PD_VARIANT && STANDBY_O && CE_I && PIN_I != pin_reg |-> ##[1:4] !STANDBY_O;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on pin change");
  property p_wake_vld;
    !PD_VARIANT && $fell(STANDBY_O) |-> !OUT_VALID_O ##1 OUT_VALID_O;
  endproperty
  a_wake_vld: assert property (p_wake_vld) else $error("wake delay wrong");
  property p_sby_vld;
    STANDBY_O |-> !OUT_VALID_O;
  endproperty
  a_sby_vld: assert property (p_sby_vld) else $error("valid in standby");
  property p_prog;
    $rose(PROG_BUSY_O) |-> (PROG_BUSY_O && Q_OE_O == '0) [*5] ##1 (!PROG_BUSY_O && FB_O == '0);
  endproperty
  a_prog: assert property (p_prog) else $error("erase cycle wrong");
  c_sleep: cover property ($rose(STANDBY_O));
  c_prog: cover property ($rose(PROG_BUSY_O));
  c_pre: cover property (run && $rose(DEV_CLK_I) && PRELOAD_EN_I);
endmodule : sby_chk
bind standby_reset_ctrl sby_chk #(.N_PINS(N_PINS), .N_MACRO(N_MACRO), .PD_VARIANT(PD_VARIANT)) u_chk (.*);
`default_nettype wire

// *** sim/sys_logic.sv ***
// Model of the system logic that drives the pins and the device clock.
// Assumes the device reports the end of power-up reset on ready_i.
`timescale 1ns/100ps
`default_nettype none
module sys_logic #(
  parameter int N = 22
) (
  // Clock and status
  input  wire logic    clk_i,
  input  wire logic    ready_i,
  // Driven pins
  output logic [N-1:0] pin_o,
  output logic         dclk_o,
  output logic         pd_o
);
  initial
  begin
    pin_o  = '0;
    dclk_o = 1'b0;
    pd_o   = 1'b0;
  end
  task automatic dev_edge();
    wait (ready_i === 1'b1);
    @(posedge clk_i);
    #1 dclk_o = 1'b1;
    @(posedge clk_i);
    #1 dclk_o = 1'b0;
  endtask : dev_edge
  task automatic set_pd(input logic v);
    @(posedge clk_i);
    #1 pd_o = v;
  endtask : set_pd
  task automatic flip(input int k);
    @(posedge clk_i);
    #1 pin_o[k] = ~pin_o[k];
  endtask : flip
  // A pulse that no sample edge can see.
  task automatic glitch(input int k);
    @(posedge clk_i);
    #2 pin_o[k] = ~pin_o[k];
    #0.5 pin_o[k] = ~pin_o[k];
  endtask : glitch
endmodule : sys_logic
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the standby and reset controller.
// Runs both standby variants side by side with a shortened power-up count.
`timescale 1ns/100ps
`default_nettype none
`include "standby_defs.svh"
module tb_top;
  localparam int POR = 4;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce = 1'b1;
  logic       pre_en = 1'b0;
  logic       prog = 1'b0;
  logic [9:0] d = '0, pre_d = '0, inv = '0, oe = '0;
  logic [9:0] q, qoe, fb;
  logic [21:0] pin, arr, arr_pd;
  logic       sby_pd, vld_pd;
  logic       dclk, pd, sby, vld, rdone, busy;
  int         err_count = 0;
  int         n_checks = 0;
  int         cyc = 0;
  always #5 clk = ~clk;
  standby_reset_ctrl #(.POR_C(POR)) u_dut (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce), .PIN_I(pin), .DEV_CLK_I(dclk),
    .POWER_DOWN_PIN_I(pd), .D_I(d), .PRELOAD_EN_I(pre_en), .PRELOAD_DATA_I(pre_d),
    .PROG_START_I(prog), .PROG_INV_I(inv), .PROG_OE_I(oe), .Q_O(q), .Q_OE_O(qoe),
    .FB_O(fb), .ARRAY_IN_O(arr), .STANDBY_O(sby), .OUT_VALID_O(vld),
    .RESET_DONE_O(rdone), .PROG_BUSY_O(busy));
  standby_reset_ctrl #(.POR_C(POR), .PD_VARIANT(1'b1)) u_dut_pd (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce), .PIN_I(pin), .DEV_CLK_I(dclk),
    .POWER_DOWN_PIN_I(pd), .D_I(d), .PRELOAD_EN_I(pre_en), .PRELOAD_DATA_I(pre_d),
    .PROG_START_I(prog), .PROG_INV_I(inv), .PROG_OE_I(oe), .Q_O(), .Q_OE_O(),
    .FB_O(), .ARRAY_IN_O(arr_pd), .STANDBY_O(sby_pd), .OUT_VALID_O(vld_pd),
    .RESET_DONE_O(), .PROG_BUSY_O());
  sys_logic u_far (.clk_i(clk), .ready_i(rdone), .pin_o(pin), .dclk_o(dclk), .pd_o(pd));
  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tk
  // A pin change, then a bounded wait until outputs are valid.
  task automatic wake_up();
    u_far.flip(0);
    tk(4);
    for (int i = 0; i < 10 && vld !== 1'b1; i++)
      tk(1);
  endtask : wake_up
  task automatic t_prog();
    wake_up();
    d = 10'h3AC;
    u_far.dev_edge();
    inv = 10'h155;
    oe = 10'h3C3;
    prog = 1'b1;
    tk(1);
    prog = 1'b0;
    chk("busy", 10'h001, 10'(busy));
    chk("oe", 10'h000, qoe);
    tk(5);
    chk("busy", 10'h000, 10'(busy));
    chk("fb", 10'h000, fb);
    chk("q", 10'h155, q);
    chk("oe", 10'h3C3, qoe);
  endtask : t_prog
  task automatic t_preload();
    logic [9:0] v [3] = '{10'h3FF, 10'h000, 10'h2B6};
    wake_up();
    pre_en = 1'b1;
    d = 10'h0F0;
    foreach (v[k])
    begin
      pre_d = v[k];
      u_far.dev_edge();
      chk("fb", v[k], fb);
      chk("q", v[k] ^ inv, q);
    end
    pre_en = 1'b0;
    u_far.dev_edge();
    chk("fb", 10'h0F0, fb);
  endtask : t_preload
  task automatic t_standby();
    int n;
    wake_up();
    u_far.flip(1);
    for (n = 0; n < 40 && sby !== 1'b1; n++)
      tk(1);
    chk("idle", 10'h001, 10'(n >= 10 && n <= 25));
    chk("valid", 10'h000, 10'(vld));
    d = 10'h001;
    u_far.dev_edge();
    chk("fb", 10'h0F0, fb);
    for (n = 0; n < 8 && vld !== 1'b1; n++)
      tk(1);
    chk("valid", 10'h001, 10'(vld));
    chk("fb", 10'h0F0, fb);
    u_far.dev_edge();
    chk("fb", 10'h001, fb);
  endtask : t_standby
  task automatic t_glitch();
    int n;
    for (n = 0; n < 40 && sby !== 1'b1; n++)
      tk(1);
    u_far.glitch(2);
    tk(5);
    chk("sleep", 10'h001, 10'(sby));
    u_far.flip(3);
    u_far.flip(3);
    tk(4);
    chk("sleep", 10'h000, 10'(sby));
  endtask : t_glitch
  task automatic t_pdpin();
    int n;
    u_far.flip(`PD_PIN_IDX);
    tk(1);
    chk("arr", 10'h001, 10'(arr[`PD_PIN_IDX]));
    chk("arr_pd", 10'h000, 10'(arr_pd[`PD_PIN_IDX]));
    u_far.set_pd(1'b1);
    tk(1);
    chk("sleep_pd", 10'h001, 10'(sby_pd));
    chk("valid_pd", 10'h000, 10'(vld_pd));
    tk(3);
    chk("sleep_pd", 10'h001, 10'(sby_pd));
    u_far.set_pd(1'b0);
    for (n = 0; n < 8 && vld_pd !== 1'b1; n++)
      tk(1);
    chk("release", 10'h001, 10'(n >= 1 && n <= `PIN_REL_CYC + 1));
  endtask : t_pdpin
  task automatic t_reset();
    wake_up();
    d = 10'h3FF;
    u_far.dev_edge();
    rst_n = 1'b0;
    tk(2);
    chk("fb", 10'h000, fb);
    chk("done", 10'h000, 10'(rdone));
    rst_n = 1'b1;
    tk(POR + 1);
    chk("done", 10'h001, 10'(rdone));
    chk("q", 10'h155, q);
    chk("oe", 10'h3C3, qoe);
  endtask : t_reset
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  initial
  begin
    tk(20);
    rst_n = 1'b1;
    tk(POR + 1);
    chk("done", 10'h001, 10'(rdone));
    chk("q", 10'h000, q);
    t_prog();
    t_preload();
    t_standby();
    t_glitch();
    t_pdpin();
    t_reset();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
